// *** rtl/pll_synth_counter_chain.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_synth_counter_chain (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register port.
    input wire logic [pll_synth_pkg::ADDR_W-1:0] address,
    input wire logic [pll_synth_pkg::DATA_W-1:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [pll_synth_pkg::DATA_W-1:0] readData,
    // Divider clock pins.
    input wire logic oscIn,
    input wire logic prescalerIn,
    // Loop outputs.
    output logic prescalerModulusSelect,
    output logic coarseErrorOut,
    output logic coarseErrorOe,
    output logic lockIndicatorOut,
    output logic [pll_synth_pkg::FINE_W-1:0] fineErrorOut,
    // Interrupt.
    output logic irq
);
    import pll_synth_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    function automatic logic [REF_W-1:0] clampMin(input logic [REF_W-1:0] v,
                                                  input logic [REF_W-1:0] lo);
        clampMin = (v < lo) ? lo : v;
    endfunction : clampMin

    function automatic logic [FINE_W-1:0] fineValue(input logic [ERR_W-1:0] err,
                                                    input logic lead);
        logic [ERR_W-1:0] sat;
        sat = (err > FINE_SPAN) ? FINE_SPAN : err;
        fineValue = lead ? FINE_MID + sat : FINE_MID - sat;
    endfunction : fineValue

    // Pin synchronisers and rising-edge enables.
    logic [1:0] oscSync_q;
    logic [1:0] preSync_q;
    logic oscPrev_q;
    logic prePrev_q;
    logic oscEn;
    logic preEn;

    assign oscEn = oscSync_q[1] & ~oscPrev_q;
    assign preEn = preSync_q[1] & ~prePrev_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oscSync_q <= 2'h0;
            preSync_q <= 2'h0;
            oscPrev_q <= 1'b0;
            prePrev_q <= 1'b0;
        end else begin
            oscSync_q <= {oscSync_q[0], oscIn};
            preSync_q <= {preSync_q[0], prescalerIn};
            oscPrev_q <= oscSync_q[1];
            prePrev_q <= preSync_q[1];
        end
    end

    // Register port decode.
    logic wrRef;
    logic wrMain;
    logic wrSw;
    logic wrApply;
    logic wrIrqEn;
    logic wrIrqClr;
    assign wrRef = writeStrobe && address == REG_REF_RATIO;
    assign wrMain = writeStrobe && address == REG_MAIN_RATIO;
    assign wrSw = writeStrobe && address == REG_SWALLOW;
    assign wrApply = writeStrobe && address == REG_CTRL && writeData[CTRL_APPLY];
    assign wrIrqEn = writeStrobe && address == REG_IRQ_ENABLE;
    assign wrIrqClr = writeStrobe && address == REG_IRQ_CLEAR;

    // Pending and active ratios.
    logic [REF_W-1:0] refPend_q;
    logic [MAIN_W-1:0] mainPend_q;
    logic [SW_W-1:0] swPend_q;
    logic [REF_W-1:0] refAct_q;
    logic [MAIN_W-1:0] mainAct_q;
    logic [SW_W-1:0] swAct_q;
    seq_t seq_q;
    logic counterClear;
    logic counterLoad;
    logic running;

    assign counterClear = (seq_q == SEQ_CLEARING);
    assign counterLoad = (seq_q == SEQ_LOADING);
    assign running = (seq_q == SEQ_RUN);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            refPend_q <= REF_MIN;
            mainPend_q <= MAIN_MIN;
            swPend_q <= SW_MIN;
        end else begin
            if (wrRef) refPend_q <= clampMin(writeData[REF_W-1:0], REF_MIN);
            if (wrMain) mainPend_q <= MAIN_W'(clampMin(REF_W'(writeData[MAIN_W-1:0]),
                                                       REF_W'(MAIN_MIN)));
            if (wrSw) swPend_q <= SW_W'(clampMin(REF_W'(writeData[SW_W-1:0]),
                                                 REF_W'(SW_MIN)));
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            seq_q <= SEQ_CLEARING;
            refAct_q <= REF_MIN;
            mainAct_q <= MAIN_MIN;
            swAct_q <= SW_MIN;
        end else begin
            case (seq_q)
                SEQ_CLEARING: begin
                    refAct_q <= refPend_q;
                    mainAct_q <= mainPend_q;
                    swAct_q <= swPend_q;
                    seq_q <= SEQ_LOADING;
                end
                SEQ_LOADING: seq_q <= SEQ_RUN;
                default: if (wrApply) seq_q <= SEQ_CLEARING;
            endcase
        end
    end

    // Counter chains.
    logic rDone;
    logic aDone;
    logic mDone;
    logic aActive_q;
    logic half_q;
    logic refEvent;
    logic mainEvent;

    ratio_counter #(.W(REF_W)) refCounter (
        .clock(clock),
        .rst_n(rst_n),
        .clear(counterClear),
        .load(counterLoad),
        .tick(oscEn & running),
        .loadValue(refAct_q),
        .done(rDone)
    );

    ratio_counter #(.W(SW_W)) swallowCounter (
        .clock(clock),
        .rst_n(rst_n),
        .clear(counterClear),
        .load(counterLoad),
        .tick(preEn & running & aActive_q),
        .loadValue(swAct_q),
        .done(aDone)
    );

    ratio_counter #(.W(MAIN_W)) mainCounter (
        .clock(clock),
        .rst_n(rst_n),
        .clear(counterClear),
        .load(counterLoad),
        .tick(preEn & running),
        .loadValue(mainAct_q),
        .done(mDone)
    );

    assign refEvent = rDone & half_q;
    assign mainEvent = mDone;

    always_ff @(posedge clock) begin
        if (!rst_n || counterClear || counterLoad) begin
            prescalerModulusSelect <= 1'b0;
            aActive_q <= 1'b1;
            half_q <= 1'b0;
        end else begin
            half_q <= half_q ^ rDone;
            if (mDone) begin
                prescalerModulusSelect <= 1'b0;
                aActive_q <= 1'b1;
            end else if (aDone) begin
                prescalerModulusSelect <= 1'b1;
                aActive_q <= 1'b0;
            end
        end
    end

    // Phase/frequency detector.
    logic up_q;
    logic dn_q;
    logic [ERR_W-1:0] err_q;
    logic [FINE_W-1:0] hold_q;
    logic upNext;
    logic dnNext;
    logic endCmp;
    logic inWindow;
    logic coarseOn;

    assign upNext = up_q | refEvent;
    assign dnNext = dn_q | mainEvent;
    assign endCmp = upNext & dnNext;
    assign inWindow = (err_q < LOCK_WINDOW);
    assign coarseOn = (up_q | dn_q) & ~endCmp & ~inWindow;

    always_ff @(posedge clock) begin
        if (!rst_n || counterClear) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            err_q <= '0;
        end else if (endCmp) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            err_q <= '0;
        end else begin
            up_q <= upNext;
            dn_q <= dnNext;
            if ((up_q | dn_q) && err_q != ERR_MAX) err_q <= err_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            coarseErrorOut <= 1'b0;
            coarseErrorOe <= 1'b0;
            lockIndicatorOut <= 1'b1;
            hold_q <= FINE_MID;
            fineErrorOut <= FINE_MID;
        end else begin
            coarseErrorOut <= up_q;
            coarseErrorOe <= coarseOn;
            if (endCmp) begin
                lockIndicatorOut <= ~inWindow;
                hold_q <= fineValue(err_q, up_q);
            end
            if (refEvent) fineErrorOut <= hold_q;
        end
    end

    // Interrupt status, enable and clear; a new event beats a clear.
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqEn_q;
    logic [IRQ_W-1:0] irqSet;
    assign irqSet[IRQ_LOCK_GAIN] = endCmp & inWindow & lockIndicatorOut;
    assign irqSet[IRQ_LOCK_LOSS] = endCmp & ~inWindow & ~lockIndicatorOut;
    assign irqSet[IRQ_RELOADED] = counterLoad;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irqStat_q <= '0;
            irqEn_q <= '0;
            irq <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~(wrIrqClr ? writeData[IRQ_W-1:0] : '0)) | irqSet;
            if (wrIrqEn) irqEn_q <= writeData[IRQ_W-1:0];
            irq <= |(irqStat_q & irqEn_q);
        end
    end

    // Read data, valid in the cycle after the read strobe.
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] readData_d;
    assign statusWord = DATA_W'({fineErrorOut, {(ST_FINE_LSB - ST_MOD_SEL - 1){1'b0}},
                                 prescalerModulusSelect, coarseErrorOe, ~lockIndicatorOut});
    assign readData_d = !readStrobe ? '0 :
                        address == REG_REF_RATIO ? DATA_W'(refPend_q) :
                        address == REG_MAIN_RATIO ? DATA_W'(mainPend_q) :
                        address == REG_SWALLOW ? DATA_W'(swPend_q) :
                        address == REG_STATUS ? statusWord :
                        address == REG_IRQ_STATUS ? DATA_W'(irqStat_q) :
                        address == REG_IRQ_ENABLE ? DATA_W'(irqEn_q) : '0;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readData <= '0;
        end else begin
            readData <= readData_d;
        end
    end

    // Checks; the helper counts reference completions since the last reference event.
    logic [1:0] refPasses_q;
    always_ff @(posedge clock) begin
        if (!rst_n || counterClear || counterLoad || refEvent) refPasses_q <= 2'h0;
        else if (rDone) refPasses_q <= refPasses_q + 2'h1;
    end
    property p_refRange; running |-> refAct_q >= REF_MIN; endproperty
    a_refRange: assert property (p_refRange) else $error("reference ratio below 3");
    property p_refHalf; rDone |-> refEvent == (refPasses_q == 2'h1); endproperty
    a_refHalf: assert property (p_refHalf) else $error("second reference pass missing");
    property p_mainRange; counterLoad |-> mainAct_q >= MAIN_MIN && swAct_q >= SW_MIN; endproperty
    a_mainRange: assert property (p_mainRange) else $error("main or swallow ratio low");
    property p_modHigh; aDone && !mDone |=> prescalerModulusSelect && !aActive_q; endproperty
    a_modHigh: assert property (p_modHigh) else $error("select not high after swallow");
    property p_modLow; mDone |=> !prescalerModulusSelect && aActive_q; endproperty
    a_modLow: assert property (p_modLow) else $error("select not low after main");
    property p_clearLoad; rst_n && counterClear |=> counterLoad ##1 running; endproperty
    a_clearLoad: assert property (p_clearLoad) else $error("clear not followed by load");
    property p_coarseFloat; endCmp |=> !coarseErrorOe; endproperty
    a_coarseFloat: assert property (p_coarseFloat) else $error("coarse driven after compare");
    property p_lockLow; endCmp && inWindow |=> !lockIndicatorOut && !coarseErrorOe; endproperty
    a_lockLow: assert property (p_lockLow) else $error("lock not shown in window");
    property p_fineSample; refEvent && !endCmp |=> fineErrorOut == $past(hold_q); endproperty
    a_fineSample: assert property (p_fineSample) else $error("fine output not sampled");
    property p_stepEdge; mDone || aDone |-> preEn && $rose(preSync_q[1]) && running; endproperty
    a_stepEdge: assert property (p_stepEdge) else $error("main chain stepped off edge");
    property p_cmpClear; endCmp |=> !up_q && !dn_q && err_q == '0; endproperty
    a_cmpClear: assert property (p_cmpClear) else $error("detector not cleared");

    c_lock: cover property (@(posedge clock) disable iff (!rst_n) $fell(lockIndicatorOut));
    c_coarse: cover property (@(posedge clock) disable iff (!rst_n) $rose(coarseErrorOe));
    c_reload: cover property (@(posedge clock) disable iff (!rst_n) wrApply ##[1:3] counterLoad);
    c_modSel: cover property (@(posedge clock) disable iff (!rst_n) $rose(prescalerModulusSelect));
endmodule : pll_synth_counter_chain
`default_nettype wire

// *** rtl/pll_synth_pkg.sv ***
`default_nettype none
package pll_synth_pkg;
    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Counter widths and ratio limits.
    localparam int REF_W = 11;
    localparam int MAIN_W = 10;
    localparam int SW_W = 7;
    localparam logic [REF_W-1:0] REF_MIN = 11'h003;
    localparam logic [MAIN_W-1:0] MAIN_MIN = 10'h003;
    localparam logic [SW_W-1:0] SW_MIN = 7'h01;

    // Phase detector sizing, in system clock cycles of phase error.
    localparam int ERR_W = 8;
    localparam int FINE_W = 8;
    localparam logic [ERR_W-1:0] LOCK_WINDOW = 8'h04;
    localparam logic [ERR_W-1:0] ERR_MAX = 8'hFF;
    localparam logic [FINE_W-1:0] FINE_MID = 8'h80;
    localparam logic [ERR_W-1:0] FINE_SPAN = 8'h7F;

    // Register offsets.
    localparam logic [ADDR_W-1:0] REG_REF_RATIO = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MAIN_RATIO = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SWALLOW = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h18;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h1C;

    // Field positions.
    localparam int CTRL_APPLY = 0;
    localparam int ST_LOCKED = 0;
    localparam int ST_COARSE_ON = 1;
    localparam int ST_MOD_SEL = 2;
    localparam int ST_FINE_LSB = 8;
    localparam int IRQ_W = 3;
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_RELOADED = 2;

    typedef enum {
        SEQ_RUN,
        SEQ_CLEARING,
        SEQ_LOADING
    } seq_t;
endpackage : pll_synth_pkg
`default_nettype wire

// *** rtl/ratio_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module ratio_counter #(
    parameter int W = 11
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Control.
    input wire logic clear,
    input wire logic load,
    input wire logic tick,
    input wire logic [W-1:0] loadValue,
    // Completion of one count cycle.
    output logic done
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic atOne;

    assign atOne = (count_q == W'(1));
    assign done = tick & atOne;
    // A zero state or a finished cycle reloads the ratio on the next tick.
    assign count_d = (atOne || count_q == '0) ? loadValue : count_q - W'(1);

    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= loadValue;
        end else if (tick) begin
            count_q <= count_d;
        end
    end
endmodule : ratio_counter
`default_nettype wire

// *** sim/prescaler_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module prescaler_model #(
    parameter int N = 4
) (
    // Oscillator being divided and the modulus control.
    input wire logic vcoClock,
    input wire logic modulusSelect,
    // Divided output and the length of the period just ended.
    output logic divOut,
    output int lastLen
);
    int count = 0;
    int length = N + 1;
    initial begin
        divOut = 1'b0;
        lastLen = 0;
    end
    // modulus early in period
    // The modulus is sampled early in each period, on the second VCO edge after divOut rises, when divOut falls.
    always @(posedge vcoClock) begin
        if (count + 1 >= length) begin
            count <= 0;
            lastLen <= length;
            divOut <= 1'b1;
        end else begin
            count <= count + 1;
            if (count == 1) begin
                divOut <= 1'b0;
                length <= modulusSelect ? N : N + 1;
            end
        end
    end
endmodule : prescaler_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pll_synth_pkg::*;
    localparam int N = 4;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] address = 8'h00;
    logic [DATA_W-1:0] writeData = 32'h0;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic oscIn = 1'b0;
    logic vcoClock = 1'b0;
    wire logic [DATA_W-1:0] readData;
    wire logic prescalerIn;
    wire logic modSel;
    wire logic coarseOut;
    wire logic coarseOe;
    wire logic lockOut;
    wire logic [FINE_W-1:0] fineOut;
    wire logic irq;
    int lastLen;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int edges = 0;
    int lowEdges = 0;
    int vcoSum = 0;
    logic [DATA_W-1:0] value;
    logic [ADDR_W-1:0] regAddr [6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08};
    logic [DATA_W-1:0] regIn [6] = '{32'h1, 32'h7FF, 32'hFFFF, 32'h2, 32'h0, 32'h7F};
    logic [DATA_W-1:0] regOut [6] = '{32'h3, 32'h7FF, 32'h3FF, 32'h3, 32'h1, 32'h7F};
    int cfg [3][3] = '{'{3, 3, 1}, '{5, 5, 4}, '{4, 7, 3}};

    always #50 clock = ~clock;
    always #200 oscIn = ~oscIn;
    always #200 vcoClock = ~vcoClock;

    pll_synth_counter_chain pll_synth_counter_chain_inst (
        .clock(clock), .rst_n(rst_n), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .oscIn(oscIn), .prescalerIn(prescalerIn), .prescalerModulusSelect(modSel),
        .coarseErrorOut(coarseOut), .coarseErrorOe(coarseOe),
        .lockIndicatorOut(lockOut), .fineErrorOut(fineOut), .irq(irq)
    );
    prescaler_model #(.N(N)) prescaler_model_inst (
        .vcoClock(vcoClock), .modulusSelect(modSel), .divOut(prescalerIn), .lastLen(lastLen)
    );

    always begin
        @(posedge prescalerIn);
        #1;
        edges++;
        if (modSel === 1'b0) lowEdges++;
        vcoSum += lastLen;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            $display("unexpected at %0t: run timed out", $time);
            complete_run();
        end
    end

    task complete_run();
        $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expected, input string what);
        checks_done++;
        if (seen !== expected) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, expected);
        end
    endtask : check

    task wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        @(posedge clock);
        address <= addr;
        writeData <= data;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr

    task rd(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
        @(posedge clock);
        address <= addr;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        data = readData;
    endtask : rd

    task program_chain(input int r, input int m, input int a);
        wr(REG_REF_RATIO, DATA_W'(r));
        wr(REG_MAIN_RATIO, DATA_W'(m));
        wr(REG_SWALLOW, DATA_W'(a));
        wr(REG_CTRL, 32'h1);
    endtask : program_chain

    // Waits for a rising modulus select, bounded.
    task wait_rise();
        logic prev;
        prev = modSel;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clock);
            #1;
            if (prev === 1'b0 && modSel === 1'b1) return;
            prev = modSel;
        end
        check(32'h0, 32'h1, "modulus select rise");
    endtask : wait_rise

    initial begin
        repeat (5) @(posedge clock);
        #1;
        check(readData, 32'h0, "reset read data");
        check(DATA_W'(modSel), 32'h0, "reset modulus select");
        check(DATA_W'(coarseOe), 32'h0, "reset coarse enable");
        check(DATA_W'(lockOut), 32'h1, "reset lock");
        check(DATA_W'(fineOut), DATA_W'(FINE_MID), "reset fine");
        check(DATA_W'(irq), 32'h0, "reset irq");
        @(posedge clock);
        rst_n <= 1'b1;
        $display("test reset finished");

        for (int i = 0; i < 6; i++) begin
            wr(regAddr[i], regIn[i]);
            rd(regAddr[i], value);
            check(value, regOut[i], "ratio readback");
        end
        rd(8'h20, value);
        check(value, 32'h0, "unmapped read");
        @(posedge clock);
        #1;
        check(readData, 32'h0, "read data after its cycle");
        $display("test registers finished");

        // Swallow never above main and loop ratio at least N*N-N.
        for (int i = 0; i < 3; i++) begin
            program_chain(cfg[i][0], cfg[i][1], cfg[i][2]);
            repeat (2) @(posedge clock);
            #1;
            check(DATA_W'(modSel), 32'h0, "modulus select after reload");
            wait_rise();
            edges = 0;
            lowEdges = 0;
            vcoSum = 0;
            wait_rise();
            check(DATA_W'(edges), DATA_W'(cfg[i][1]), "main count");
            check(DATA_W'(lowEdges), DATA_W'(cfg[i][2]), "swallow count");
            check(DATA_W'(vcoSum), DATA_W'(N * cfg[i][1] + cfg[i][2]), "loop ratio");
        end
        $display("test division finished");

        for (int i = 0; i < 3000 && coarseOe !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        #1;
        check(DATA_W'(coarseOe), 32'h1, "coarse driven");
        check(DATA_W'(coarseOut), 32'h1, "reference leads");
        check(DATA_W'(lockOut), 32'h1, "not locked");
        rd(REG_STATUS, value);
        check(value & 32'h1, 32'h0, "status lock bit");
        $display("test coarse detector finished");

        wr(REG_IRQ_ENABLE, 32'h1 << IRQ_RELOADED);
        wr(REG_IRQ_CLEAR, 32'h7);
        repeat (2) @(posedge clock);
        #1;
        check(DATA_W'(irq), 32'h0, "irq after clear");
        wr(REG_CTRL, 32'h1);
        repeat (4) @(posedge clock);
        #1;
        check(DATA_W'(irq), 32'h1, "irq after reload");
        rd(REG_IRQ_STATUS, value);
        check(value & 32'h4, 32'h4, "reload status");
        wr(REG_IRQ_CLEAR, 32'h4);
        repeat (2) @(posedge clock);
        #1;
        check(DATA_W'(irq), 32'h0, "irq cleared");
        wr(REG_IRQ_ENABLE, 32'h0);
        wr(REG_CTRL, 32'h1);
        repeat (4) @(posedge clock);
        #1;
        check(DATA_W'(irq), 32'h0, "irq masked");
        rd(REG_IRQ_STATUS, value);
        check(value & 32'h4, 32'h4, "masked status sticky");
        rd(REG_IRQ_ENABLE, value);
        check(value, 32'h0, "enable readback");
        $display("test interrupt finished");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
